/* current_channel_wave_rms.v */
// Current channel waveform sampling, RMS and serial register access.
`timescale 1ns/1ps
`include "current_channel_consts.vh"
module current_channel_wave_rms (
  input wire i_clk,
  input wire i_rst,
  input wire [23:0] i_sample,
  input wire i_sample_valid,
  input wire i_sclk,
  input wire i_din,
  input wire i_cs_n,
  output reg o_dout,
  output reg o_irq_n
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted when last two agree.
  reg [2:0] sclk_sync;
  reg [2:0] din_sync;
  reg [2:0] cs_sync;
  reg sclk_f;
  reg din_f;
  reg cs_f;
  reg sclk_prev;
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sclk_sync <= 3'h0;
      din_sync <= 3'h0;
      cs_sync <= 3'h7;
      sclk_f <= 1'b0;
      din_f <= 1'b0;
      cs_f <= 1'b1;
      sclk_prev <= 1'b0;
    end
    else
    begin
      sclk_sync <= {sclk_sync[1:0], i_sclk};
      din_sync <= {din_sync[1:0], i_din};
      cs_sync <= {cs_sync[1:0], i_cs_n};
      if (sclk_sync[1] == sclk_sync[2])
        sclk_f <= sclk_sync[2];
      if (din_sync[1] == din_sync[2])
        din_f <= din_sync[2];
      if (cs_sync[1] == cs_sync[2])
        cs_f <= cs_sync[2];
      sclk_prev <= sclk_f;
    end
  end
  wire sclk_fall;
  wire sclk_rise;
  assign sclk_fall = sclk_prev & ~sclk_f & ~cs_f;
  assign sclk_rise = ~sclk_prev & sclk_f & ~cs_f;

  ////////////////////////////////////////////////////////////////////////
  // Registers and sample path.
  reg [15:0] mode;
  reg [15:0] irq_enable;
  reg [15:0] status;
  reg [11:0] current_rms_offset_trim;
  reg [23:0] waveform_sample;
  reg [23:0] current_rms_value;
  reg [23:0] latest;
  wire rate_tick;
  clock_divider_tick rate_gen (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_rate(mode[`MODE_RATE_HI:`MODE_RATE_LO]),
    .o_tick(rate_tick)
  );
  wire wave_event;
  // Sampling only taps the stream, so power paths upstream never stall.
  assign wave_event = rate_tick &&
    (mode[`MODE_SRC_HI:`MODE_SRC_LO] == `MODE_SRC_CURRENT);

  ////////////////////////////////////////////////////////////////////////
  // RMS: squares averaged by a first-order low pass, then square root.
  reg [47:0] mean_sq;
  reg [1:0] upd_count;
  wire [47:0] sq;
  wire signed [24:0] sx;
  wire signed [49:0] sx_prod;
  wire signed [48:0] corr;
  wire signed [48:0] trimmed;
  wire [47:0] root_in;
  wire [23:0] root;
  wire root_done;
  assign sx = {latest[23], latest};
  // Full-width product; a 25-bit self-sized product would drop the top bits.
  assign sx_prod = sx * sx;
  assign sq = sx_prod[47:0];
  assign corr = {{22{current_rms_offset_trim[11]}},
    current_rms_offset_trim, 15'h0000};
  assign trimmed = $signed({1'b0, mean_sq}) + corr;
  assign root_in = trimmed[48] ? 48'h000000000000 : trimmed[47:0];
  isqrt_seq rms_root (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(upd_count == 2'h0),
    .i_value(root_in),
    .o_root(root),
    .o_done(root_done)
  );
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      latest <= 24'h000000;
      mean_sq <= 48'h000000000000;
      upd_count <= 2'h0;
      current_rms_value <= 24'h000000;
    end
    else
    begin
      if (i_sample_valid)
        latest <= i_sample;
      upd_count <= upd_count + 2'h1;
      if (upd_count == 2'h0)
        mean_sq <= mean_sq - (mean_sq >> `AVG_SHIFT) +
          (sq >> `AVG_SHIFT);
      // Root is in sample units, so one bit equals one sample bit.
      if (root_done)
        current_rms_value <= root;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial port: command byte, then data shifted most significant first.
  localparam ST_CMD = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WRITE = 2'h2;
  reg [1:0] state;
  reg [4:0] bit_count;
  reg [7:0] cmd;
  reg [23:0] shift;
  reg [23:0] wdata;
  reg [4:0] nbits;
  reg rclr_active;
  reg [15:0] clear_mask;
  reg [23:0] rdata;
  reg [4:0] rbits;
  wire [7:0] next_cmd;
  assign next_cmd = {cmd[6:0], din_f};
  always @*
  begin
    rdata = 24'h000000;
    rbits = 5'h10;
    case (next_cmd[5:0])
      `ADDR_WAVEFORM_SAMPLE:
      begin
        rdata = waveform_sample;
        rbits = 5'h18;
      end
      `ADDR_CURRENT_RMS_VALUE:
      begin
        rdata = current_rms_value;
        rbits = 5'h18;
      end
      `ADDR_CURRENT_RMS_OFFSET_TRIM:
      begin
        rdata = {current_rms_offset_trim, 12'h000};
      end
      `ADDR_MODE: rdata = {mode, 8'h00};
      `ADDR_IRQ_ENABLE: rdata = {irq_enable, 8'h00};
      `ADDR_STATUS: rdata = {status, 8'h00};
      `ADDR_STATUS_READ_CLEAR: rdata = {status, 8'h00};
      default: rdata = 24'h000000;
    endcase
  end
  wire status_done;
  assign status_done = (state == ST_READ) && rclr_active && sclk_fall &&
    (bit_count == nbits - 5'h01);
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= ST_CMD;
      bit_count <= 5'h00;
      cmd <= 8'h00;
      shift <= 24'h000000;
      wdata <= 24'h000000;
      nbits <= 5'h10;
      rclr_active <= 1'b0;
      clear_mask <= 16'h0000;
      o_dout <= 1'b0;
      mode <= `MODE_RESET;
      irq_enable <= `IRQ_ENABLE_RESET;
      current_rms_offset_trim <= `TRIM_RESET;
      waveform_sample <= 24'h000000;
      status <= 16'h0000;
      o_irq_n <= 1'b1;
    end
    else
    begin
      if (cs_f)
      begin
        state <= ST_CMD;
        bit_count <= 5'h00;
        rclr_active <= 1'b0;
      end
      else
      case (state)
        ST_CMD:
        begin
          if (sclk_fall)
          begin
            cmd <= next_cmd;
            bit_count <= bit_count + 5'h01;
            if (bit_count == 5'h07)
            begin
              bit_count <= 5'h00;
              if (next_cmd[7])
              begin
                state <= ST_WRITE;
                nbits <= (next_cmd[5:0] == `ADDR_CURRENT_RMS_OFFSET_TRIM ||
                  next_cmd[5:0] == `ADDR_MODE ||
                  next_cmd[5:0] == `ADDR_IRQ_ENABLE) ? 5'h10 : 5'h08;
              end
              else
              begin
                state <= ST_READ;
                shift <= rdata;
                nbits <= rbits;
                o_dout <= rdata[23];
                rclr_active <= (next_cmd[5:0] == `ADDR_STATUS_READ_CLEAR);
                clear_mask <= status;
              end
            end
          end
        end
        ST_READ:
        begin
          if (sclk_rise)
          begin
            shift <= {shift[22:0], 1'b0};
            o_dout <= shift[22];
          end
          if (sclk_fall)
          begin
            bit_count <= bit_count + 5'h01;
            if (bit_count == nbits - 5'h01)
              state <= ST_CMD;
          end
        end
        ST_WRITE:
        begin
          if (sclk_fall)
          begin
            wdata <= {wdata[22:0], din_f};
            bit_count <= bit_count + 5'h01;
            if (bit_count == nbits - 5'h01)
            begin
              state <= ST_CMD;
              bit_count <= 5'h00;
              case (cmd[5:0])
                `ADDR_MODE: mode <= {wdata[14:0], din_f};
                `ADDR_IRQ_ENABLE: irq_enable <= {wdata[14:0], din_f};
                `ADDR_CURRENT_RMS_OFFSET_TRIM:
                  current_rms_offset_trim <= {wdata[10:0], din_f};
                default: mode <= mode;
              endcase
            end
          end
        end
        default: state <= ST_CMD;
      endcase
      // Flags set regardless of enables; a new event beats the clear.
      if (wave_event)
        waveform_sample <= latest;
      status <= (status & ~(status_done ? clear_mask : 16'h0000)) |
        (wave_event ? (16'h0001 << `BIT_SAMPLE_READY) : 16'h0000);
      // Released from command byte end through the whole status-with-clear data.
      if (rclr_active && state == ST_READ)
        o_irq_n <= 1'b1;
      else if (state == ST_CMD && sclk_fall && bit_count == 5'h07 &&
        !next_cmd[7] && next_cmd[5:0] == `ADDR_STATUS_READ_CLEAR)
        o_irq_n <= 1'b1;
      else
        o_irq_n <= ~|(status & irq_enable);
    end
  end
endmodule

/* current_channel_consts.vh */
// Constants for the current channel waveform and RMS back end.
// Operation
// - Samples are signed 24-bit words, at most one per four clocks.
// - Full-scale codes span about 2851ec to d7ae14, equal magnitude.
// - Mode bits 14:13 equal to 1,0 route samples to the waveform register.
// - Power and energy paths keep running during waveform sampling.
// - Four sample rates chosen by mode bits 12:11.
// - Interrupt output goes low when each new waveform sample is ready.
// - Waveform sample is shifted as three bytes, most significant first.
// - Interrupt stays low until the host reads the status with clear.
// - RMS is root of the mean of squared samples, alongside voltage RMS.
// - RMS result is unsigned 24-bit, from every input sample, whatever the mode source.
// - One RMS bit equals one waveform sample bit.
// - RMS result updates once every 28 clocks; the mean square every four.
// - Full-scale sine gives RMS near 1c82b3.
// - A 12-bit signed host-written offset trims the RMS.
// - Corrected RMS is root of RMS squared plus offset times 32768.
// - Status with clear at address 0c clears flags and releases interrupt.
// - Interrupt released at command byte end, reasserted after if pending.
// - Flags set regardless of enables; enables only gate the interrupt.
`ifndef CURRENT_CHANNEL_CONSTS_VH
`define CURRENT_CHANNEL_CONSTS_VH
`define ADDR_WAVEFORM_SAMPLE 6'h01
`define ADDR_MODE 6'h09
`define ADDR_IRQ_ENABLE 6'h0a
`define ADDR_STATUS 6'h0b
`define ADDR_STATUS_READ_CLEAR 6'h0c
`define ADDR_CURRENT_RMS_VALUE 6'h16
`define ADDR_CURRENT_RMS_OFFSET_TRIM 6'h18
`define MODE_SRC_HI 14
`define MODE_SRC_LO 13
`define MODE_RATE_HI 12
`define MODE_RATE_LO 11
`define MODE_SRC_CURRENT 2'h2
`define BIT_SAMPLE_READY 3
`define MODE_RESET 16'h000c
`define IRQ_ENABLE_RESET 16'h0040
`define TRIM_RESET 12'h000
`define BASE_RATE_DIV 128
`define OFFSET_SCALE_SHIFT 15
`define RMS_UPDATE_DIV 4
`define AVG_SHIFT 10
`endif

/* clock_divider_tick.v */
// Programmable tick generator for the waveform output rate.
`timescale 1ns/1ps
`include "current_channel_consts.vh"
module clock_divider_tick (
  input wire i_clk,
  input wire i_rst,
  input wire [1:0] i_rate,
  output reg o_tick
);
  reg [9:0] count;
  wire [9:0] limit;
  // Rate code n divides by 128 shifted left n times.
  assign limit = (10'h080 << i_rate) - 10'h001;
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      count <= 10'h000;
      o_tick <= 1'b0;
    end
    else
    begin
      o_tick <= (count >= limit);
      if (count >= limit)
        count <= 10'h000;
      else
        count <= count + 10'h001;
    end
  end
endmodule

/* isqrt_seq.v */
// Sequential integer square root of a 48-bit value, 24-bit result.
`timescale 1ns/1ps
module isqrt_seq (
  input wire i_clk,
  input wire i_rst,
  input wire i_start,
  input wire [47:0] i_value,
  output reg [23:0] o_root,
  output reg o_done
);
  reg [47:0] rem;
  reg [23:0] root;
  reg [4:0] step;
  reg busy;
  wire [23:0] trial;
  wire [47:0] trial_sq;
  assign trial = root | (24'h800000 >> step);
  assign trial_sq = trial * trial;
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rem <= 48'h000000000000;
      root <= 24'h000000;
      step <= 5'h00;
      busy <= 1'b0;
      o_root <= 24'h000000;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      if (!busy && i_start)
      begin
        rem <= i_value;
        root <= 24'h000000;
        step <= 5'h00;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (trial_sq <= rem)
          root <= trial;
        if (step == 5'h17)
        begin
          busy <= 1'b0;
          o_done <= 1'b1;
          o_root <= (trial_sq <= rem) ? trial : root;
        end
        step <= step + 5'h01;
      end
    end
  end
endmodule

/* current_channel_wave_rms_properties.sv */
// Pin-level checks for the current channel back end.
`timescale 1ns/1ps
module current_channel_wave_rms_properties (
  input wire i_clk,
  input wire i_rst,
  input wire i_sclk,
  input wire i_cs_n,
  input wire o_dout,
  input wire o_irq_n
);
  reg sclk_q;
  reg cs_q;
  reg [4:0] since_edge;
  reg [4:0] since_fall;
  reg [4:0] since_sel;
  // Counters saturate so long idle spans never wrap back into range.
  always @(posedge i_clk)
  begin
    sclk_q <= i_sclk;
    cs_q <= i_cs_n;
    if (i_rst || i_sclk != sclk_q || i_cs_n != cs_q)
      since_edge <= 5'h0;
    else if (since_edge != 5'h1f)
      since_edge <= since_edge + 5'h1;
    if (!i_rst && sclk_q && !i_sclk)
      since_fall <= 5'h0;
    else if (i_rst || since_fall != 5'h1f)
      since_fall <= i_rst ? 5'h1f : since_fall + 5'h1;
    if (!i_rst && !i_cs_n)
      since_sel <= 5'h0;
    else if (i_rst || since_sel != 5'h1f)
      since_sel <= i_rst ? 5'h1f : since_sel + 5'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_release;
    $rose(o_irq_n);
  endsequence
  sequence s_raise;
    $fell(o_irq_n);
  endsequence
  a_irq_reset_high: assert property (disable iff (1'b0) $fell(i_rst) |-> o_irq_n)
    else $error("irq low after reset");
  a_dout_reset_low: assert property (disable iff (1'b0) $fell(i_rst) |-> !o_dout)
    else $error("dout high after reset");
  a_release_on_fall: assert property (s_release |-> since_fall <= 5'd10)
    else $error("irq released away from a clock fall");
  a_release_holds: assert property (s_release |=> o_irq_n [*8])
    else $error("irq not held high during status data");
  a_release_in_frame: assert property (s_release |-> since_sel <= 5'd16)
    else $error("irq released outside an access");
  a_raise_holds: assert property (s_raise |=> !o_irq_n [*8])
    else $error("irq pulse too short");
  a_low_until_read: assert property (!o_irq_n && since_sel > 5'd16 |=> !o_irq_n)
    else $error("irq released with no access");
  a_dout_on_edge: assert property (!$stable(o_dout) |-> since_edge <= 5'd10)
    else $error("dout moved without a serial edge");
endmodule
bind current_channel_wave_rms current_channel_wave_rms_properties u_props (
  .i_clk(i_clk), .i_rst(i_rst), .i_sclk(i_sclk), .i_cs_n(i_cs_n),
  .o_dout(o_dout), .o_irq_n(o_irq_n));

/* host_spi_model.sv */
// Host side of the serial port: frames commands and shifts data.
`timescale 1ns/1ps
module host_spi_model (
  input wire i_clk,
  input wire i_dout,
  output reg o_sclk,
  output reg o_din,
  output reg o_cs_n
);
  initial
  begin
    o_sclk = 1'b0;
    o_din = 1'b1;
    o_cs_n = 1'b1;
  end
  task automatic half_wait();
    repeat (8) @(posedge i_clk);
  endtask
  // Clock idles low between frames; data idles inverted so stale bits show.
  task automatic xfer(input logic [7:0] cmd, input int nbits,
    input logic [23:0] wdata, output logic [23:0] rdata);
    logic [31:0] word;
    word = {cmd, wdata << (24 - nbits)};
    rdata = 24'h0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    // Data in changes on the rise so it is steady across the sampling fall.
    // Data out is taken before the rise, which moves the next bit out.
    for (int i = 0; i < 8 + nbits; i++)
    begin
      half_wait();
      if (i >= 8)
        rdata = {rdata[22:0], i_dout};
      o_din <= word[31 - i];
      o_sclk <= 1'b1;
      half_wait();
      o_sclk <= 1'b0;
    end
    half_wait();
    o_cs_n <= 1'b1;
    o_din <= ~o_din;
    half_wait();
  endtask
endmodule

/* current_channel_wave_rms_tb_top.sv */
// Self-checking bench for the current channel waveform and RMS block.
`timescale 1ns/1ps
`include "current_channel_consts.vh"
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin \
  errors++; $display("Error %0t: got %0h want %0h", $time, got, exp); end end
module current_channel_wave_rms_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [23:0] sample = 24'h0;
  logic sample_valid = 1'b0;
  logic sclk;
  logic din;
  logic cs_n;
  logic dout;
  logic irq_n;
  logic [23:0] samp = 24'h2851ec;
  logic alt = 1'b0;
  logic flip = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [23:0] d;
  logic [11:0] trims [3] = '{12'h100, 12'hf00, 12'hc00};
  int roots [3] = '{5016, 2896, 0};
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int t0;
  int t1;
  always #10 clk = ~clk;
  // A sample every fourth clock; alternating signs exercise the squaring.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    phase <= phase + 2'h1;
    sample_valid <= (phase == 2'h3);
    if (phase == 2'h3)
    begin
      flip <= ~flip;
      sample <= (alt && flip) ? 24'h0 - samp : samp;
    end
  end
  current_channel_wave_rms u_current_channel_wave_rms (
    .i_clk(clk), .i_rst(rst), .i_sample(sample),
    .i_sample_valid(sample_valid), .i_sclk(sclk), .i_din(din),
    .i_cs_n(cs_n), .o_dout(dout), .o_irq_n(irq_n));
  host_spi_model u_host_spi_model (
    .i_clk(clk), .i_dout(dout), .o_sclk(sclk), .o_din(din), .o_cs_n(cs_n));
  ////////////////////////////////////////////////////////////////////////////
  task automatic rd(input logic [5:0] a, input int n, output logic [23:0] q);
    u_host_spi_model.xfer({2'b00, a}, n, 24'h0, q);
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] v);
    logic [23:0] q;
    u_host_spi_model.xfer({2'b10, a}, 16, {8'h0, v}, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input int n, input logic [23:0] e);
    logic [23:0] q;
    rd(a, n, q);
    `CHECK(q, e)
  endtask
  task automatic wait_low(output int t);
    for (int n = 0; n < 3000 && irq_n !== 1'b0; n++)
      @(posedge clk);
    t = cyc;
  endtask
  // Only a fall that follows a clear ending with irq high is tick aligned.
  task automatic tick_time(output int t);
    for (int k = 0; k < 4; k++)
    begin
      rd(`ADDR_STATUS_READ_CLEAR, 16, d);
      if (irq_n === 1'b1)
        k = 9;
    end
    wait_low(t);
  endtask
  function automatic logic near(input logic [23:0] g, input int e);
    return ({8'h0, g} + 32'd8 >= e) && ({8'h0, g} <= e + 8);
  endfunction
  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic close_out();
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (100000) @(posedge clk);
    errors++;
    close_out();
  end
  initial
  begin
    do_reset();
    `CHECK(irq_n, 1'b1)
    rd_chk(`ADDR_MODE, 16, 24'h00000c);
    rd_chk(`ADDR_IRQ_ENABLE, 16, 24'h000040);
    rd_chk(6'h3f, 16, 24'h0);
    wr(`ADDR_CURRENT_RMS_OFFSET_TRIM, 16'hfabc);
    rd_chk(`ADDR_CURRENT_RMS_OFFSET_TRIM, 16, 24'h00abc0);
    wr(`ADDR_MODE, 16'h400c);
    repeat (400) @(posedge clk);
    `CHECK(irq_n, 1'b1)
    rd_chk(`ADDR_STATUS, 16, 24'h8);
    wr(`ADDR_IRQ_ENABLE, 16'h0008);
    wait_low(t0);
    `CHECK(irq_n, 1'b0)
    rd_chk(`ADDR_WAVEFORM_SAMPLE, 24, 24'h2851ec);
    samp = 24'hd7ae14;
    repeat (300) @(posedge clk);
    rd_chk(`ADDR_WAVEFORM_SAMPLE, 24, 24'hd7ae14);
    wr(`ADDR_MODE, 16'h000c);
    repeat (300) @(posedge clk);
    `CHECK(irq_n, 1'b0)
    rd_chk(`ADDR_STATUS_READ_CLEAR, 16, 24'h8);
    `CHECK(irq_n, 1'b1)
    rd_chk(`ADDR_STATUS_READ_CLEAR, 16, 24'h0);
    for (int r = 3; r >= 0; r--)
    begin
      wr(`ADDR_MODE, 16'h400c | (16'(r) << 11));
      tick_time(t0);
      tick_time(t1);
      rd_chk(`ADDR_STATUS_READ_CLEAR, 16, 24'h8);
      if (r >= 2)
        `CHECK(t1 - t0, 128 << r)
    end
    samp = 24'h001000;
    alt = 1'b1;
    do_reset();
    repeat (32768) @(posedge clk);
    rd(`ADDR_CURRENT_RMS_VALUE, 24, d);
    `CHECK(near(d, 4096), 1'b1)
    for (int i = 0; i < 3; i++)
    begin
      wr(`ADDR_CURRENT_RMS_OFFSET_TRIM, {4'h0, trims[i]});
      rd(`ADDR_CURRENT_RMS_VALUE, 24, d);
      `CHECK(near(d, roots[i]), 1'b1)
    end
    close_out();
  end
endmodule
